// ---- cmsgf_pkg.sv ----
// constants for the clock selector, synchronous gate and four-pair fanout
// What this block does
// - select pin high routes the alternate clock, low routes the primary clock.
// - an unconnected select pin reads low, so the primary clock is chosen.
// - enable pin high enables outputs; unconnected it reads high, enabled by default.
// - with enable low all true outputs are low and all complements are high.
// - when enabled all four pairs carry the selected clock and its inversion.
// - outputs start or stop only while already low, so no runt pulse occurs.
// - enable is captured on the selected clock's rising edge and loaded into the gate flip-flop on its falling edge.
// - enable change takes effect only after one rising then one falling edge.
package cmsgf_pkg;
   localparam int unsigned NUM_PAIRS = 4;
   localparam int unsigned NUM_SYNC_BITS = 8;
   // bit positions in the synchronised pin vector
   localparam int unsigned PRI_TRUE_BIT = 0;
   localparam int unsigned PRI_COMP_BIT = 1;
   localparam int unsigned ALT_TRUE_BIT = 2;
   localparam int unsigned ALT_COMP_BIT = 3;
   localparam int unsigned SEL_BIT = 4;
   localparam int unsigned SEL_DRV_BIT = 5;
   localparam int unsigned EN_BIT = 6;
   localparam int unsigned EN_DRV_BIT = 7;
   // reset values and open-pin levels
   localparam logic [7:0] SYNC_RST = 8'h00;
   localparam logic SEL_OPEN_LEVEL = 1'b0;
   localparam logic EN_OPEN_LEVEL = 1'b1;
   localparam logic GATE_RST = 1'b1;
   localparam logic ARMED_RST = 1'b1;
   localparam logic PREV_RST = 1'b0;
   localparam logic [3:0] TRUE_RST = 4'h0;
   localparam logic [3:0] COMP_RST = 4'hF;
endpackage

// ---- cmsgf_top.sv ----
// clock selector with falling-edge synchronous gate and 1-to-4 differential fanout
`timescale 1ns/1ps
module cmsgf_top (
   // system clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // primary differential clock input
   input wire logic pri_clk_true,
   input wire logic pri_clk_comp,
   // alternate differential clock input
   input wire logic alt_clk_true,
   input wire logic alt_clk_comp,
   // source select pin and its connected indication
   input wire logic src_sel,
   input wire logic src_sel_driven,
   // output gate enable pin and its connected indication
   input wire logic gate_en,
   input wire logic gate_en_driven,
   // fanout output pairs
   output logic [3:0] fanout_output_pair_true,
   output logic [3:0] fanout_output_pair_comp
);

   // limitation: the input clocks are sampled, so each level must last at least
   // three system cycles; outputs lag the pins by three cycles and carry one
   // cycle of sampling jitter, traded for a single clock domain
   // pin capture stages
   logic [7:0] pins_raw;
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   // control levels after the open-pin defaults
   logic sel_eff;
   logic en_eff;
   // decoded clocks, the selected one and its edges
   logic pri_lvl;
   logic alt_lvl;
   logic clk_lvl;
   logic clk_prev_reg;
   logic clk_rise;
   logic clk_fall;
   // two-step enable path: armed on a rise, loaded into the gate on a fall
   logic armed_reg;
   logic gate_reg;
   // output stage
   logic [3:0] true_reg;
   logic [3:0] comp_reg;
   logic [3:0] true_next;

   assign pins_raw = {gate_en_driven, gate_en, src_sel_driven, src_sel,
                      alt_clk_comp, alt_clk_true, pri_clk_comp, pri_clk_true};

   // every pin is foreign to the system clock, so all pass two flip-flops
   // the driven flags travel with their pins, so a pin and its open flag stay aligned
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= cmsgf_pkg::SYNC_RST;
         sync2_reg <= cmsgf_pkg::SYNC_RST;
      end else begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
      end
   end

   // open pins fall back to their pull levels
   assign sel_eff = sync2_reg[cmsgf_pkg::SEL_DRV_BIT] ? sync2_reg[cmsgf_pkg::SEL_BIT]
                                                       : cmsgf_pkg::SEL_OPEN_LEVEL;
   assign en_eff = sync2_reg[cmsgf_pkg::EN_DRV_BIT] ? sync2_reg[cmsgf_pkg::EN_BIT]
                                                     : cmsgf_pkg::EN_OPEN_LEVEL;

   // differential decode: high only when true is above complement
   assign pri_lvl = sync2_reg[cmsgf_pkg::PRI_TRUE_BIT] & ~sync2_reg[cmsgf_pkg::PRI_COMP_BIT];
   assign alt_lvl = sync2_reg[cmsgf_pkg::ALT_TRUE_BIT] & ~sync2_reg[cmsgf_pkg::ALT_COMP_BIT];
   // select is not resynchronised to the clock, switching live may glitch
   assign clk_lvl = sel_eff ? alt_lvl : pri_lvl;

   // routing checks; an open select must override whatever the pin floats to
   a_pri_routed: assert property (@(posedge clock) disable iff (!rst_b)
      (!sel_eff && gate_reg) |=> (true_reg == {4{$past(pri_lvl)}}))
      else $error("primary clock not routed when select low");

   a_open_sel_override: assert property (@(posedge clock) disable iff (!rst_b)
      (!sync2_reg[cmsgf_pkg::SEL_DRV_BIT] && sync2_reg[cmsgf_pkg::SEL_BIT] && gate_reg) |=>
      (true_reg == {4{$past(pri_lvl)}}))
      else $error("open select floating high did not keep primary clock");

   // edge tracking of the selected clock
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         clk_prev_reg <= cmsgf_pkg::PREV_RST;
      end else begin
         clk_prev_reg <= clk_lvl;
      end
   end

   assign clk_rise = clk_lvl & ~clk_prev_reg;
   assign clk_fall = ~clk_lvl & clk_prev_reg;

   // arming on the rising edge means a change needs a full rise then fall
   // a change that lands just before a fall waits for the next rise and fall
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         armed_reg <= cmsgf_pkg::ARMED_RST;
      end else if (clk_rise) begin
         armed_reg <= en_eff;
      end
   end

   // arming checks; an open enable pin arms even if it floats low
   a_arm_tracks_en: assert property (@(posedge clock) disable iff (!rst_b)
      clk_rise |=> (armed_reg == $past(en_eff)))
      else $error("armed flag did not take the enable on a rise");

   a_arm_on_rise: assert property (@(posedge clock) disable iff (!rst_b)
      $changed(armed_reg) |-> $past(clk_rise))
      else $error("armed flag moved without a clock rise");

   a_en_high_arms: assert property (@(posedge clock) disable iff (!rst_b)
      (en_eff && clk_rise) |=> armed_reg)
      else $error("high enable did not arm outputs");

   a_low_en_disarms: assert property (@(posedge clock) disable iff (!rst_b)
      (!en_eff && clk_rise) |=> !armed_reg)
      else $error("low enable did not disarm outputs");

   a_open_en_override: assert property (@(posedge clock) disable iff (!rst_b)
      (!sync2_reg[cmsgf_pkg::EN_DRV_BIT] && !sync2_reg[cmsgf_pkg::EN_BIT] && clk_rise) |=> armed_reg)
      else $error("open enable pin floating low disarmed outputs");

   // gate flip-flop moves only on the falling edge, while the clock is low
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gate_reg <= cmsgf_pkg::GATE_RST;
      end else if (clk_fall) begin
         gate_reg <= armed_reg;
      end
   end

   // the gate may only move on a fall, when the outputs are already low
   a_gate_on_fall: assert property (@(posedge clock) disable iff (!rst_b)
      $changed(gate_reg) |-> $past(clk_fall))
      else $error("gate moved without a falling edge");

   a_gate_change_low: assert property (@(posedge clock) disable iff (!rst_b)
      $changed(gate_reg) |-> (true_reg == 4'h0))
      else $error("gate moved while outputs were high");

   // fanout: each pair carries the gated clock and its inversion
   // two flops per pair, true and complement, keep each output straight from a register, at one cycle of lag
   genvar gi;
   generate
      for (gi = 0; gi < cmsgf_pkg::NUM_PAIRS; gi++) begin : g_pair
         assign true_next[gi] = clk_lvl & gate_reg;
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               true_reg[gi] <= cmsgf_pkg::TRUE_RST[gi];
               comp_reg[gi] <= cmsgf_pkg::COMP_RST[gi];
            end else begin
               true_reg[gi] <= true_next[gi];
               comp_reg[gi] <= ~true_next[gi];
            end
         end
      end
   endgenerate

   assign fanout_output_pair_true = true_reg;
   assign fanout_output_pair_comp = comp_reg;

   // output edges must follow edges of the selected clock, never the gate alone
   a_out_rise_aligned: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(true_reg[0]) |-> $past(clk_rise))
      else $error("output rose without a clock rise");

   a_out_fall_aligned: assert property (@(posedge clock) disable iff (!rst_b)
      $fell(true_reg[0]) |-> $past(clk_fall))
      else $error("output fell without a clock fall");

   a_rise_sets_out: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_rise && gate_reg) |=> (true_reg == 4'hF))
      else $error("enabled outputs did not rise with the clock");

   a_fall_clears_out: assert property (@(posedge clock) disable iff (!rst_b)
      clk_fall |=> (true_reg == 4'h0))
      else $error("outputs did not fall with the clock");

   a_comp_follows: assert property (@(posedge clock) disable iff (!rst_b)
      gate_reg |=> (comp_reg == ~{4{$past(clk_lvl)}}))
      else $error("complement outputs not the inverted clock");

   // checks kept beside the logic
   a_alt_routed: assert property (@(posedge clock) disable iff (!rst_b)
      (sel_eff && gate_reg) |=> (true_reg == {4{$past(alt_lvl)}}))
      else $error("alternate clock not routed when selected");

   a_open_sel_primary: assert property (@(posedge clock) disable iff (!rst_b)
      (!sync2_reg[cmsgf_pkg::SEL_DRV_BIT] && gate_reg) |=> (true_reg == {4{$past(pri_lvl)}}))
      else $error("open select did not choose primary clock");

   a_open_en_arms: assert property (@(posedge clock) disable iff (!rst_b)
      (!sync2_reg[cmsgf_pkg::EN_DRV_BIT] && clk_rise) |=> armed_reg)
      else $error("open enable did not arm outputs");

   a_disabled_levels: assert property (@(posedge clock) disable iff (!rst_b)
      !gate_reg |=> (true_reg == 4'h0 && comp_reg == 4'hF))
      else $error("disabled outputs not at low true and high complement");

   a_pairs_complement: assert property (@(posedge clock) disable iff (!rst_b)
      (comp_reg == ~true_reg) && (true_reg == 4'h0 || true_reg == 4'hF))
      else $error("output pairs not matched or not complementary");

   a_gate_while_low: assert property (@(posedge clock) disable iff (!rst_b)
      $changed(gate_reg) |-> (!$past(clk_lvl) && $past(true_next) == 4'h0))
      else $error("gate changed while the clock was high");

   a_fall_capture: assert property (@(posedge clock) disable iff (!rst_b)
      clk_fall |=> (gate_reg == $past(armed_reg)))
      else $error("gate not captured on falling edge");

   a_rise_then_fall: assert property (@(posedge clock) disable iff (!rst_b)
      (!clk_fall && !clk_rise) |=> ($stable(gate_reg) && $stable(armed_reg)))
      else $error("enable path moved without a clock edge");

endmodule

// ---- cmsgf_clk_src.sv ----
// free-running board clock sources feeding both differential inputs
`timescale 1ns/1ps
module cmsgf_clk_src (
   // bench clock and half periods in system cycles
   input wire logic clock,
   input wire logic [3:0] half_pri,
   input wire logic [3:0] half_alt,
   // differential clock pins
   output logic pri_true,
   output logic pri_comp,
   output logic alt_true,
   output logic alt_comp
);
   logic [3:0] cnt_p = 4'h1;
   logic [3:0] cnt_a = 4'h1;
   logic pri_lvl = 1'b0;
   logic alt_lvl = 1'b0;
   // oscillators never stop, so the comp leg is always the inverse
   assign pri_true = pri_lvl;
   assign alt_true = alt_lvl;
   assign pri_comp = ~pri_lvl;
   assign alt_comp = ~alt_lvl;
   // each level lasts at least three system cycles, slow enough to be sampled
   always @(posedge clock) begin
      cnt_p <= (cnt_p >= half_pri) ? 4'h1 : cnt_p + 4'h1;
      cnt_a <= (cnt_a >= half_alt) ? 4'h1 : cnt_a + 4'h1;
      if (cnt_p >= half_pri) pri_lvl <= ~pri_lvl;
      if (cnt_a >= half_alt) alt_lvl <= ~alt_lvl;
   end
endmodule

// ---- tb_clock_mux_sync_gate_fanout.sv ----
// random and corner tests of the selector, synchronous gate and fanout
`timescale 1ns/1ps
module tb_clock_mux_sync_gate_fanout;
   logic clock = 1'b0, rst_b = 1'b0, sel = 1'b0, sel_drv = 1'b1, en = 1'b1, en_drv = 1'b1;
   logic pt, pc, at, ac;
   logic [3:0] hp = 4'h3, ha = 4'h5, o_t, o_c, po = 4'h0;
   logic [7:0] h = 8'h00;
   int fails = 0, n_tests = 0;
   cmsgf_clk_src src_u (.clock(clock), .half_pri(hp), .half_alt(ha), .pri_true(pt), .pri_comp(pc),
      .alt_true(at), .alt_comp(ac));
   cmsgf_top dut_u (.clock(clock), .rst_b(rst_b), .pri_clk_true(pt), .pri_clk_comp(pc), .alt_clk_true(at),
      .alt_clk_comp(ac), .src_sel(sel), .src_sel_driven(sel_drv), .gate_en(en), .gate_en_driven(en_drv),
      .fanout_output_pair_true(o_t), .fanout_output_pair_comp(o_c));
   initial forever #2.5 clock = ~clock;
   // expected true outputs: the delayed selected clock when enabled, low when disabled
   function automatic logic [3:0] exp_true(input int mode, input logic lvl);
      return (mode == 1) ? {4{lvl}} : 4'h0;
   endfunction
   // mode 0 disabled, 1 enabled, 2 in transition, 3 history only; h[3] is the pin three edges back
   task automatic step(input int mode);
      @(negedge clock);
      h = {h[6:0], (sel & sel_drv) ? at : pt};
      if (mode < 3) begin
         n_tests++;
         if (o_c !== ~o_t || (mode < 2 && o_t !== exp_true(mode, h[3]))
             || (o_t !== 4'h0 && o_t !== {4{h[3]}}) || (o_t !== po && (o_t == 4'h0 ? h[3] : h[4]))) begin
            fails++;
            $display("CHECK FAILED fanout mode %0d exp %h got %h/%h", mode, exp_true(mode, h[3]), o_t, o_c);
         end
      end
      po = o_t;
   endtask
   task automatic run(input int n, input int mode);
      repeat (n) step(mode);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // bound well above the roughly 1500 cycles the tests need
   initial begin
      #40000;
      fails++;
      end_sim();
   end
   initial begin
      void'($urandom(32'hc3a19aba));
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      run(8, 3);
      run(40, 1);
      $display("test start-up done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clock);
         en <= 1'b0;
         en_drv <= 1'b1;
         hp <= 4'(3 + $urandom % 6);
         ha <= 4'(3 + $urandom % 6);
         run(40, 2);
         run(20, 0);
         @(posedge clock);
         sel <= (i < 4) ? i[0] : 1'($urandom);
         sel_drv <= (i == 3) ? 1'b0 : 1'($urandom % 4 != 0);
         run(20, 0);
         @(posedge clock);
         en <= (i == 2) ? 1'b0 : 1'b1;
         en_drv <= (i == 2 || i == 5) ? 1'b0 : 1'b1;
         run(40, 2);
         run(60, 1);
         $display("test %0d done sel %0d driven %0d", i, sel, sel_drv);
      end
      end_sim();
   end
endmodule
